// ==== logic/flash_seq_defs.svh ====
// Constants for the flash erase-verify and once-field command sequencer
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH

// Command codes, high byte of parameter slot 0
`define CMD_VERIFY_BLOCK 8'h02
`define CMD_VERIFY_SECTION 8'h03
`define CMD_READ_ONCE 8'h04
`define CMD_PROGRAM_ONCE 8'h07

// Slot index expected at launch for each command
`define SLOT_VERIFY_BLOCK 3'h0
`define SLOT_VERIFY_SECTION 3'h2
`define SLOT_READ_ONCE 3'h1
`define SLOT_PROGRAM_ONCE 3'h5

// Field positions inside slot 0
`define CMD_MSB 15
`define CMD_LSB 8
`define ADDR_HI_MSB 1
`define ADDR_HI_LSB 0

// One bit per value of global address [17:16] that selects a program-flash block
`define VALID_BLOCK_MASK 4'hC

// Phrases in one 128 Kbyte span (8 bytes per phrase)
`define BLOCK_PHRASES 16384
`define PHRASE_BYTES 18'h00008
`define ALIGN_BITS 3

// Once field: 8 phrases of 64 bytes total in the information area
`define ONCE_PHRASES 8
`define ONCE_BASE 18'h00000
`define ONCE_INDEX_MAX 16'h0007

// Value of an erased phrase
`define ERASED_PHRASE 64'hFFFF_FFFF_FFFF_FFFF

// Reset values
`define FLAG_RESET 1'h0
`define COMPLETE_RESET 1'h1
`define SLOT_RESET 16'h0000

`endif

// ==== logic/flash_seq_pkg.sv ====
// Types shared by the flash command sequencer files
package flash_seq_pkg;

  typedef enum {
    ST_IDLE,
    ST_CHECK,
    ST_READ,
    ST_PGM,
    ST_DONE
  } seq_state_t;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_VBLK,
    CMD_VSEC,
    CMD_RONCE,
    CMD_PONCE
  } cmd_kind_t;

  typedef logic [15:0] param_word_t;

endpackage

// ==== logic/phrase_reader.sv ====
// Sequential phrase reader with erase and compare checking
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defs.svh"

module phrase_reader #(
  parameter int AW = 18,
  parameter int DW = 64,
  parameter int CW = 17
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [AW-1:0] base_addr,
  input wire logic [CW-1:0] count,
  input wire logic info_sel,
  input wire logic check_blank,
  input wire logic [DW-1:0] expect_data,
  output logic rd_req_q,
  output logic [AW-1:0] rd_addr_q,
  output logic rd_info_q,
  input wire logic rd_ack,
  input wire logic [DW-1:0] rd_data,
  input wire logic rd_ecc_err,
  input wire logic rd_ecc_uncorr,
  output logic done_q,
  output logic mismatch_q,
  output logic ecc_err_q,
  output logic uncorr_q,
  output logic [DW-1:0] last_data_q
);

  logic [CW-1:0] left_q;
  logic [DW-1:0] expect_q;
  logic blank_q;
  logic [DW-1:0] ref_word;

  assign ref_word = blank_q ? DW'(`ERASED_PHRASE) : expect_q;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_req_q <= 1'b0;
      rd_addr_q <= '0;
      rd_info_q <= 1'b0;
      left_q <= '0;
      done_q <= 1'b0;
      expect_q <= '0;
      blank_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        rd_addr_q <= base_addr;
        rd_info_q <= info_sel;
        left_q <= count;
        expect_q <= expect_data;
        blank_q <= check_blank;
        // An empty range finishes at once without touching the array
        rd_req_q <= (count != '0);
        done_q <= (count == '0);
      end else if (rd_req_q && rd_ack) begin
        left_q <= left_q - CW'(1);
        rd_addr_q <= rd_addr_q + AW'(`PHRASE_BYTES);
        if (left_q == CW'(1)) begin
          rd_req_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mismatch_q <= 1'b0;
      ecc_err_q <= 1'b0;
      uncorr_q <= 1'b0;
      last_data_q <= '0;
    end else if (start) begin
      mismatch_q <= 1'b0;
      ecc_err_q <= 1'b0;
      uncorr_q <= 1'b0;
    end else if (rd_req_q && rd_ack) begin
      last_data_q <= rd_data;
      if (rd_data != ref_word) begin
        mismatch_q <= 1'b1;
      end
      if (rd_ecc_err || rd_ecc_uncorr) begin
        ecc_err_q <= 1'b1;
      end
      if (rd_ecc_uncorr) begin
        uncorr_q <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ==== logic/flash_verify_once.sv ====
// Flash command sequencer for erase-verify, read-once and program-once commands
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defs.svh"

// Summary of operation
// - Block verify flags access error unless slot index is zero at launch.
// - Block verify flags access error when address bits 17:16 name no block.
// - Erase-verify reads set verify error on any error, uncorrectable on bad ECC.
// - Section verify checks the range is erased, then sets completion flag.
// - Section verify flags access error unless slot index is two at launch.
// - Commands not permitted in current mode or security raise access error.
// - Section verify flags access error for an invalid 18-bit start address.
// - Section verify flags access error when start address bits 2:0 are nonzero.
// - Section verify flags access error if range crosses a 128 Kbyte boundary.
// - Read-once reads one of eight phrases of the 64-byte information field.
// - Program-once checks phrase blank, programs it, then reads it back.
// - Completion flag stays low until program-once has fully finished.
// - Once field is never erased; a written phrase cannot be programmed again.
// - Program-once accepts phrase index 0 to 7, else access error.
// - Program-flash reads return invalid data during program-once.
// - Program-once flags access error unless slot index is five at launch.
// - Program-once on an already programmed phrase raises access error.
// - Program-once read-back sets verify error and uncorrectable error as found.
module flash_verify_once
  import flash_seq_pkg::*;
#(
  parameter int BLOCK_PHRASES = `BLOCK_PHRASES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic param_wr,
  input wire logic [2:0] param_slot,
  input wire logic [15:0] param_data,
  input wire logic launch,
  input wire logic verify_permitted,
  input wire logic once_permitted,
  output logic command_complete_flag_q,
  output logic [2:0] command_slot_index_q,
  output logic access_error_flag_q,
  output logic protection_violation_flag_q,
  output logic verify_error_flag_q,
  output logic uncorrectable_error_flag_q,
  output logic [63:0] read_once_data_q,
  output logic pflash_read_invalid_q,
  output logic rd_req_q,
  output logic [17:0] rd_addr_q,
  output logic rd_info_q,
  input wire logic rd_ack,
  input wire logic [63:0] rd_data,
  input wire logic rd_ecc_err,
  input wire logic rd_ecc_uncorr,
  output logic pgm_req_q,
  output logic [17:0] pgm_addr_q,
  output logic [63:0] pgm_data_q,
  input wire logic pgm_ack
);

  localparam int CW = 17;

  seq_state_t state_q;
  cmd_kind_t cmd_q;
  param_word_t slot_q [0:5];
  logic verify_phase_q;

  logic rdr_start_q;
  logic [17:0] rdr_base_q;
  logic [CW-1:0] rdr_count_q;
  logic rdr_info_q;
  logic rdr_blank_q;
  logic rdr_done;
  logic rdr_mismatch;
  logic rdr_ecc_err;
  logic rdr_uncorr;
  logic [63:0] rdr_data;

  cmd_kind_t cmd_d;
  logic chk_err;
  logic [17:0] glob_addr;
  logic [1:0] blk_sel;
  logic [CW-1:0] sec_end;
  logic [63:0] once_word;
  logic [17:0] once_addr;

  ////////////////////////////////////////////////////////////////////////
  // Launch decode and parameter checks
  assign blk_sel = slot_q[0][`ADDR_HI_MSB:`ADDR_HI_LSB];
  assign glob_addr = {blk_sel, slot_q[1]};
  assign sec_end = {3'h0, glob_addr[16:`ALIGN_BITS] & 14'(BLOCK_PHRASES - 1)} + {1'b0, slot_q[2]};
  assign once_word = {slot_q[2], slot_q[3], slot_q[4], slot_q[5]};
  assign once_addr = 18'(`ONCE_BASE) + {12'h000, slot_q[1][2:0], 3'h0};

  always_comb begin
    case (slot_q[0][`CMD_MSB:`CMD_LSB])
      `CMD_VERIFY_BLOCK: cmd_d = CMD_VBLK;
      `CMD_VERIFY_SECTION: cmd_d = CMD_VSEC;
      `CMD_READ_ONCE: cmd_d = CMD_RONCE;
      `CMD_PROGRAM_ONCE: cmd_d = CMD_PONCE;
      default: cmd_d = CMD_NONE;
    endcase
  end

  always_comb begin
    chk_err = 1'b0;
    case (cmd_q)
      CMD_VBLK: begin
        if (command_slot_index_q != `SLOT_VERIFY_BLOCK) begin
          chk_err = 1'b1;
        end
        if (((`VALID_BLOCK_MASK >> blk_sel) & 4'h1) == 4'h0) begin
          chk_err = 1'b1;
        end
        if (!verify_permitted) begin
          chk_err = 1'b1;
        end
      end
      CMD_VSEC: begin
        if (command_slot_index_q != `SLOT_VERIFY_SECTION) begin
          chk_err = 1'b1;
        end
        if (!verify_permitted) begin
          chk_err = 1'b1;
        end
        if (((`VALID_BLOCK_MASK >> glob_addr[17:16]) & 4'h1) == 4'h0) begin
          chk_err = 1'b1;
        end
        if (glob_addr[`ALIGN_BITS-1:0] != 3'h0) begin
          chk_err = 1'b1;
        end
        if (sec_end > CW'(BLOCK_PHRASES)) begin
          chk_err = 1'b1;
        end
      end
      CMD_RONCE: begin
        if (command_slot_index_q != `SLOT_READ_ONCE) begin
          chk_err = 1'b1;
        end
        if (!once_permitted || slot_q[1] > `ONCE_INDEX_MAX) begin
          chk_err = 1'b1;
        end
      end
      CMD_PONCE: begin
        if (command_slot_index_q != `SLOT_PROGRAM_ONCE) begin
          chk_err = 1'b1;
        end
        if (!once_permitted) begin
          chk_err = 1'b1;
        end
        if (slot_q[1] > `ONCE_INDEX_MAX) begin
          chk_err = 1'b1;
        end
      end
      default: chk_err = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Parameter slots; writes while a command runs are ignored
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      command_slot_index_q <= 3'h0;
      for (int i = 0; i < 6; i++) begin
        slot_q[i] <= `SLOT_RESET;
      end
    end else if (param_wr && command_complete_flag_q && param_slot <= 3'h5) begin
      command_slot_index_q <= param_slot;
      slot_q[param_slot] <= param_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command sequence
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cmd_q <= CMD_NONE;
      verify_phase_q <= 1'b0;
      command_complete_flag_q <= `COMPLETE_RESET;
      pflash_read_invalid_q <= 1'b0;
      rdr_start_q <= 1'b0;
      rdr_base_q <= '0;
      rdr_count_q <= '0;
      rdr_info_q <= 1'b0;
      rdr_blank_q <= 1'b0;
      pgm_req_q <= 1'b0;
      pgm_addr_q <= '0;
      pgm_data_q <= '0;
    end else begin
      rdr_start_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (launch && command_complete_flag_q) begin
            command_complete_flag_q <= 1'b0;
            cmd_q <= cmd_d;
            verify_phase_q <= 1'b0;
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (chk_err) begin
            state_q <= ST_DONE;
          end else begin
            rdr_start_q <= 1'b1;
            rdr_blank_q <= (cmd_q != CMD_RONCE);
            rdr_info_q <= (cmd_q == CMD_RONCE) || (cmd_q == CMD_PONCE);
            state_q <= ST_READ;
            case (cmd_q)
              CMD_VBLK: begin
                rdr_base_q <= {blk_sel, 16'h0000};
                rdr_count_q <= CW'(BLOCK_PHRASES);
              end
              CMD_VSEC: begin
                rdr_base_q <= glob_addr;
                rdr_count_q <= {1'b0, slot_q[2]};
              end
              CMD_PONCE: begin
                // Blank check first guards against a second write
                pflash_read_invalid_q <= 1'b1;
                rdr_base_q <= once_addr;
                rdr_count_q <= CW'(1);
              end
              default: begin
                rdr_base_q <= once_addr;
                rdr_count_q <= CW'(1);
              end
            endcase
          end
        end
        ST_READ: begin
          if (rdr_done) begin
            if (cmd_q == CMD_PONCE && !verify_phase_q) begin
              if (rdr_mismatch || rdr_ecc_err) begin
                state_q <= ST_DONE;
              end else begin
                pgm_req_q <= 1'b1;
                pgm_addr_q <= once_addr;
                pgm_data_q <= once_word;
                state_q <= ST_PGM;
              end
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_PGM: begin
          if (pgm_ack) begin
            pgm_req_q <= 1'b0;
            verify_phase_q <= 1'b1;
            rdr_start_q <= 1'b1;
            rdr_blank_q <= 1'b0;
            rdr_base_q <= once_addr;
            rdr_count_q <= CW'(1);
            state_q <= ST_READ;
          end
        end
        ST_DONE: begin
          pflash_read_invalid_q <= 1'b0;
          command_complete_flag_q <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags; cleared by the next launch, set by the running command
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      access_error_flag_q <= `FLAG_RESET;
      protection_violation_flag_q <= `FLAG_RESET;
      verify_error_flag_q <= `FLAG_RESET;
      uncorrectable_error_flag_q <= `FLAG_RESET;
    end else if (state_q == ST_IDLE && launch && command_complete_flag_q) begin
      access_error_flag_q <= 1'b0;
      protection_violation_flag_q <= 1'b0;
      verify_error_flag_q <= 1'b0;
      uncorrectable_error_flag_q <= 1'b0;
    end else if (state_q == ST_CHECK && chk_err) begin
      access_error_flag_q <= 1'b1;
    end else if (state_q == ST_READ && rdr_done) begin
      case (cmd_q)
        CMD_VBLK, CMD_VSEC: begin
          verify_error_flag_q <= rdr_mismatch || rdr_ecc_err;
          uncorrectable_error_flag_q <= rdr_uncorr;
        end
        CMD_RONCE: begin
          verify_error_flag_q <= rdr_ecc_err;
          uncorrectable_error_flag_q <= rdr_uncorr;
        end
        CMD_PONCE: begin
          if (!verify_phase_q) begin
            // A written phrase is refused, so the field can never be rewritten
            access_error_flag_q <= rdr_mismatch || rdr_ecc_err;
          end else begin
            verify_error_flag_q <= rdr_mismatch || rdr_ecc_err;
            uncorrectable_error_flag_q <= rdr_uncorr;
          end
        end
        default: access_error_flag_q <= access_error_flag_q;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      read_once_data_q <= '0;
    end else if (state_q == ST_READ && rdr_done && cmd_q == CMD_RONCE) begin
      read_once_data_q <= rdr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  phrase_reader #(
    .AW(18),
    .DW(64),
    .CW(CW)
  ) u_reader (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(rdr_start_q),
    .base_addr(rdr_base_q),
    .count(rdr_count_q),
    .info_sel(rdr_info_q),
    .check_blank(rdr_blank_q),
    .expect_data(pgm_data_q),
    .rd_req_q(rd_req_q),
    .rd_addr_q(rd_addr_q),
    .rd_info_q(rd_info_q),
    .rd_ack(rd_ack),
    .rd_data(rd_data),
    .rd_ecc_err(rd_ecc_err),
    .rd_ecc_uncorr(rd_ecc_uncorr),
    .done_q(rdr_done),
    .mismatch_q(rdr_mismatch),
    .ecc_err_q(rdr_ecc_err),
    .uncorr_q(rdr_uncorr),
    .last_data_q(rdr_data)
  );

endmodule
`default_nettype wire

// ==== testbench/flash_verify_once_monitor.sv ====
// Port-level assertions for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_verify_once_monitor #(
  parameter int BLOCK_PHRASES = 16384
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic param_wr,
  input wire logic [2:0] param_slot,
  input wire logic launch,
  input wire logic verify_permitted,
  input wire logic once_permitted,
  input wire logic command_complete_flag_q,
  input wire logic [2:0] command_slot_index_q,
  input wire logic access_error_flag_q,
  input wire logic protection_violation_flag_q,
  input wire logic verify_error_flag_q,
  input wire logic uncorrectable_error_flag_q,
  input wire logic pflash_read_invalid_q,
  input wire logic rd_req_q,
  input wire logic [17:0] rd_addr_q,
  input wire logic rd_ack,
  input wire logic pgm_req_q,
  input wire logic [17:0] pgm_addr_q,
  input wire logic pgm_ack
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire start_ok = launch && command_complete_flag_q;
  wire no_mode = start_ok && !verify_permitted && !once_permitted;
  ////////////////////////////////////////////////////////////////////////////
  a_launch_clears: assert property (start_ok |=> !command_complete_flag_q
    && !access_error_flag_q && !verify_error_flag_q && !uncorrectable_error_flag_q)
    else $error("launch did not clear complete and flags");
  a_refused_fast: assert property (no_mode |=> !command_complete_flag_q [*2]
    ##1 (command_complete_flag_q && access_error_flag_q))
    else $error("refused command not completed with access error");
  a_abort_no_access: assert property (no_mode |=> (!rd_req_q && !pgm_req_q) [*3])
    else $error("refused command touched the array");
  a_slot_index_set: assert property (param_wr && command_complete_flag_q && param_slot <= 3'h5
    |=> command_slot_index_q == $past(param_slot))
    else $error("slot index not updated by parameter write");
  a_busy_slot_hold: assert property (!command_complete_flag_q |=> $stable(command_slot_index_q))
    else $error("slot index changed while busy");
  a_prot_flag_zero: assert property (protection_violation_flag_q == 1'h0)
    else $error("protection violation flag set");
  a_pgm_busy_invalid: assert property (pgm_req_q |-> !command_complete_flag_q
    && pflash_read_invalid_q)
    else $error("program running with complete high or reads valid");
  a_pgm_req_hold: assert property (pgm_req_q && !pgm_ack |=> pgm_req_q && $stable(pgm_addr_q))
    else $error("program request dropped or moved before ack");
  a_pgm_once_area: assert property (pgm_req_q |-> pgm_addr_q < 18'h00040)
    else $error("program outside the once field");
  a_rd_req_hold: assert property (rd_req_q && !rd_ack |=> rd_req_q && $stable(rd_addr_q))
    else $error("read request dropped or moved before ack");
  cover property (no_mode);
  cover property (rd_req_q && rd_ack);
  cover property (pgm_req_q && pgm_ack);
  cover property (start_ok ##[1:300] verify_error_flag_q);
endmodule
`default_nettype wire

// ==== testbench/flash_verify_once_tb.sv ====
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defs.svh"
module flash_verify_once_tb;
  // Small span keeps block verifies and boundary cases short
  localparam int BP = 16;
  logic mclk = 1'b0, rst_n = 1'b0, param_wr = 1'b0, launch = 1'b0;
  logic [2:0] param_slot = 3'h0;
  logic [15:0] param_data = 16'h0000;
  logic vp = 1'b1, op = 1'b1, rd_ack = 1'b0, ecc = 1'b0, unc_in = 1'b0, pgm_ack = 1'b0;
  logic [63:0] rd_data = 64'h0, ro_data, pgm_data, pat;
  logic cc, acc, pv, ver, unc, rinv, rd_req, rd_info, pgm_req;
  logic [2:0] six;
  logic [17:0] rd_addr, pgm_addr, a, dirty = 18'h0;
  logic inj_ecc = 1'b0, inj_unc = 1'b0;
  logic [63:0] once_mem [8];
  logic [15:0] wbuf [6];
  int seed = 32'h323e;
  int error_cnt = 0;
  int checks_done = 0;
  flash_verify_once #(.BLOCK_PHRASES(BP)) u_flash_verify_once (
    .mclk(mclk), .rst_n(rst_n), .param_wr(param_wr), .param_slot(param_slot),
    .param_data(param_data), .launch(launch), .verify_permitted(vp), .once_permitted(op),
    .command_complete_flag_q(cc), .command_slot_index_q(six), .access_error_flag_q(acc),
    .protection_violation_flag_q(pv), .verify_error_flag_q(ver),
    .uncorrectable_error_flag_q(unc), .read_once_data_q(ro_data),
    .pflash_read_invalid_q(rinv), .rd_req_q(rd_req), .rd_addr_q(rd_addr),
    .rd_info_q(rd_info), .rd_ack(rd_ack), .rd_data(rd_data), .rd_ecc_err(ecc),
    .rd_ecc_uncorr(unc_in), .pgm_req_q(pgm_req), .pgm_addr_q(pgm_addr),
    .pgm_data_q(pgm_data), .pgm_ack(pgm_ack)
  );
  initial begin
    forever #25 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Array side: random stalls; idle data is inverted so stale values never match
  always @(posedge mclk) begin
    #2;
    rd_ack = rd_req && (($random(seed) & 3) != 0);
    rd_data = !rd_ack ? ~rd_data : rd_info ? once_mem[rd_addr[5:3]] :
      (rd_addr == dirty) ? 64'h0 : `ERASED_PHRASE;
    ecc = rd_ack & inj_ecc;
    unc_in = rd_ack & inj_unc;
    pgm_ack = pgm_req && !pgm_ack && (($random(seed) & 1) == 1);
    if (pgm_ack) once_mem[pgm_addr[5:3]] = pgm_data;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_flags(input logic [2:0] got, input logic [2:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t flags got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_data(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t data got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [2:0] sec_exp(input logic [17:0] s, input int n);
    logic bad;
    logic hit;
    bad = !vp || ((`VALID_BLOCK_MASK >> s[17:16]) & 4'h1) == 4'h0 || s[2:0] != 3'h0;
    bad = bad || (int'(s[17:3]) % BP) + n > BP;
    hit = int'(dirty) >= int'(s) && int'(dirty) < int'(s) + n * 8;
    if (bad) return 3'b100;
    return {1'b0, (hit || inj_ecc) && n > 0, inj_unc && n > 0};
  endfunction
  function automatic logic [2:0] once_exp(input logic [7:0] c, input logic [15:0] x, input int n);
    logic bad;
    bad = !op || x > `ONCE_INDEX_MAX;
    if (c == `CMD_PROGRAM_ONCE)
      bad = bad || n != `SLOT_PROGRAM_ONCE + 1 || once_mem[x[2:0]] !== `ERASED_PHRASE;
    else
      bad = bad || n != `SLOT_READ_ONCE + 1;
    return {bad, 2'b00};
  endfunction
  task automatic cyc();
    @(posedge mclk);
    #2;
  endtask
  task automatic put(input logic [2:0] s, input logic [15:0] d);
    cyc();
    param_wr = 1'b1;
    param_slot = s;
    param_data = d;
    cyc();
    param_wr = 1'b0;
  endtask
  task automatic run(input int n, input logic [2:0] e);
    int k;
    for (k = 0; k < n; k++) put(k[2:0], wbuf[k]);
    cyc();
    launch = 1'b1;
    cyc();
    launch = 1'b0;
    k = 0;
    while (cc !== 1'b1 && k < 3000) begin
      cyc();
      k++;
    end
    chk_flags({2'b00, cc}, 3'b001);
    chk_flags({acc, ver, unc}, e);
  endtask
  task automatic sec(input logic [17:0] s, input int n);
    wbuf[0] = {`CMD_VERIFY_SECTION, 6'h00, s[17:16]};
    wbuf[1] = s[15:0];
    wbuf[2] = 16'(n);
    run(3, sec_exp(s, n));
  endtask
  task automatic once(input logic [7:0] c, input logic [15:0] x, input logic [63:0] d, input int n);
    wbuf[0] = {c, 8'h00};
    wbuf[1] = x;
    wbuf[2] = d[63:48];
    wbuf[3] = d[47:32];
    wbuf[4] = d[31:16];
    wbuf[5] = d[15:0];
    run(n, once_exp(c, x, n));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 8; i++) once_mem[i] = `ERASED_PHRASE;
    repeat (3) @(posedge mclk);
    #2;
    rst_n = 1'b1;
    sec(18'h20078, 1);
    sec(18'h20078, 2);
    sec(18'h20004, 1);
    sec(18'h10000, 1);
    dirty = 18'h30010;
    sec(18'h30000, 4);
    inj_ecc = 1'b1;
    inj_unc = 1'b1;
    sec(18'h30040, 2);
    inj_ecc = 1'b0;
    inj_unc = 1'b0;
    vp = 1'b0;
    op = 1'b0;
    sec(18'h30000, 1);
    vp = 1'b1;
    for (int b = 0; b < 4; b++) begin
      wbuf[0] = {`CMD_VERIFY_BLOCK, 6'h00, 2'(b)};
      run(1, sec_exp({2'(b), 16'h0000}, BP));
    end
    run(2, 3'b100);
    wbuf[0] = {`CMD_VERIFY_SECTION, 8'h03};
    run(2, 3'b100);
    once(`CMD_PROGRAM_ONCE, 16'h0001, 64'h0, 6);
    op = 1'b1;
    once(`CMD_PROGRAM_ONCE, 16'h0003, 64'h0, 5);
    for (int i = 0; i < 20; i++) begin
      a = 18'($random(seed));
      if (i % 4 != 0) a[2:0] = 3'h0;
      dirty = a + 18'(($random(seed) & 31) * 8);
      vp = (i % 5 != 0);
      sec(a, $random(seed) & 31);
    end
    for (int i = 0; i < 8; i++) begin
      pat = {$random(seed), $random(seed)};
      once(`CMD_PROGRAM_ONCE, 16'(i), pat, 6);
      once(`CMD_READ_ONCE, 16'(i), pat, 2);
      chk_data(ro_data, pat);
    end
    once(`CMD_PROGRAM_ONCE, 16'h0002, pat, 6);
    once(`CMD_PROGRAM_ONCE, 16'h0008, pat, 6);
    once(`CMD_READ_ONCE, 16'h0009, pat, 2);
    final_report();
  end
  // Whole run needs about a thousand cycles; this allows about forty times that
  initial begin
    #2000000;
    error_cnt++;
    final_report();
  end
endmodule
bind flash_verify_once flash_verify_once_monitor #(.BLOCK_PHRASES(BLOCK_PHRASES)) u_mon (
  .mclk(mclk), .rst_n(rst_n), .param_wr(param_wr), .param_slot(param_slot), .launch(launch),
  .verify_permitted(verify_permitted), .once_permitted(once_permitted),
  .command_complete_flag_q(command_complete_flag_q),
  .command_slot_index_q(command_slot_index_q), .access_error_flag_q(access_error_flag_q),
  .protection_violation_flag_q(protection_violation_flag_q),
  .verify_error_flag_q(verify_error_flag_q),
  .uncorrectable_error_flag_q(uncorrectable_error_flag_q),
  .pflash_read_invalid_q(pflash_read_invalid_q), .rd_req_q(rd_req_q), .rd_addr_q(rd_addr_q),
  .rd_ack(rd_ack), .pgm_req_q(pgm_req_q), .pgm_addr_q(pgm_addr_q), .pgm_ack(pgm_ack)
);
`default_nettype wire
